/* src/uftas_pkg.sv */
`default_nettype none
package uftas_pkg;
	// Register addresses on the plain register port
	localparam logic [31:0] UFTAS_ADDR_DATA  = 32'h5000_1000;
	localparam logic [31:0] UFTAS_ADDR_FCTL  = 32'h5000_1008;
	localparam logic [31:0] UFTAS_ADDR_FAR   = 32'h5000_1070;
	localparam logic [31:0] UFTAS_ADDR_USR   = 32'h5000_107C;
	localparam logic [31:0] UFTAS_ADDR_ISTAT = 32'h5000_1080;
	localparam logic [31:0] UFTAS_ADDR_IMASK = 32'h5000_1084;

	// Widths
	localparam int UFTAS_REG_W  = 16;
	localparam int UFTAS_CHAR_W = 8;
	localparam int UFTAS_DEPTH  = 16;
	localparam int UFTAS_INT_W  = 3;

	// Field positions
	localparam int UFTAS_FAR_BIT     = 0;
	localparam int UFTAS_FCTL_EN_BIT = 0;
	localparam int UFTAS_USR_RFF     = 4;
	localparam int UFTAS_INT_RFF     = 0;
	localparam int UFTAS_INT_TOGGLE  = 1;
	localparam int UFTAS_INT_OVR     = 2;

	// Reset values
	localparam logic                   UFTAS_FAR_RST  = 1'h0;
	localparam logic                   UFTAS_FCTL_RST = 1'h0;
	localparam logic [UFTAS_INT_W-1:0] UFTAS_INT_RST  = 3'h0;
	localparam logic [15:0]            UFTAS_ZERO_REG = 16'h0000;
	localparam logic [7:0]             UFTAS_ZERO_CH  = 8'h00;
endpackage
`default_nettype wire

/* src/uftas_fifo_if.sv */
`default_nettype none
// Connection between the register logic and one FIFO
interface uftas_fifo_if #(parameter int W = 8, parameter int D = 16);
	localparam int CW = $clog2(D + 1);
	logic          push;
	logic          pop;
	logic          flush;
	logic [W-1:0]  wdata;
	logic [W-1:0]  rdata;
	logic [CW-1:0] count;
	logic          full;
	logic          empty;
	modport fifo (input push, pop, flush, wdata, output rdata, count, full, empty);
	modport user (output push, pop, flush, wdata, input rdata, count, full, empty);
endinterface
`default_nettype wire

/* src/uftas_fifo.sv */
`default_nettype none
module uftas_fifo
	import uftas_pkg::*;
#(
	parameter int W = UFTAS_CHAR_W,
	parameter int D = UFTAS_DEPTH
)
(
	input wire logic clock,
	input wire logic rst_n,
	uftas_fifo_if.fifo  port
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [PW-1:0] LAST = PW'(D - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(D);

	logic [W-1:0]  mem_r [D];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic          do_push;
	logic          do_pop;

	// Pointer step with wrap at the last slot
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == LAST) ? '0 : p + PW'(1);
	endfunction

	// Accepted operations
	assign do_push = port.push && (count_r != FULL_CNT);
	assign do_pop  = port.pop && (count_r != '0);

	// Storage write
	always_ff @(posedge clock)
	begin
		if (do_push && !port.flush)
			mem_r[wr_ptr_r] <= port.wdata;
	end

	// Pointers and fill level, flush resets the control part only
	always_ff @(posedge clock)
	begin
		if (!rst_n || port.flush)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_r <= step(wr_ptr_r);
			if (do_pop)
				rd_ptr_r <= step(rd_ptr_r);
			if (do_push && !do_pop)
				count_r <= count_r + CW'(1);
			else if (do_pop && !do_push)
				count_r <= count_r - CW'(1);
		end
	end

	// Status seen by the user side
	assign port.rdata = mem_r[rd_ptr_r];
	assign port.count = count_r;
	assign port.full  = (count_r == FULL_CNT);
	assign port.empty = (count_r == '0);
endmodule
`default_nettype wire

/* src/uftas_top.sv */
// How it works
// RULE_01 - Test-access bit ignores writes without the build option, yet always reads back.
// RULE_02 - Test-access control sits in bit 0, resets to 0, 1 means on.
// RULE_03 - Test access with FIFOs on: writes fill receive FIFO, reads drain transmit FIFO.
// RULE_04 - Test access without FIFOs: writes load receive buffer, reads return holding register.
// RULE_05 - Switching test access on or off empties both FIFOs.
// RULE_06 - Status bit 4 reads 1 only while receive FIFO is completely full.
// RULE_07 - Full flag drops by itself once receive FIFO has a free slot.
// RULE_08 - FIFOs count as enabled while FIFO control bit 0 is 1.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module uftas_top
	import uftas_pkg::*;
#(
	parameter bit FIFO_PRESENT        = 1'b1,
	parameter bit FIFO_ACCESS_PRESENT = 1'b1,
	parameter int DEPTH               = UFTAS_DEPTH
)
(
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic [31:0]             reg_addr,
	input  wire logic [UFTAS_REG_W-1:0]  reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output var  logic [UFTAS_REG_W-1:0]  reg_rdata,
	input  wire logic                    rx_char_valid,
	input  wire logic [UFTAS_CHAR_W-1:0] rx_char_data,
	input  wire logic                    tx_char_req,
	output var  logic                    tx_char_valid,
	output var  logic [UFTAS_CHAR_W-1:0] tx_char_data,
	output var  logic                    fifo_en,
	output var  logic                    fifo_test_access_enable,
	output var  logic                    irq
);
	localparam int PADW = UFTAS_REG_W - UFTAS_CHAR_W;

	logic                    far_r;
	logic                    fctl_en_r;
	logic [UFTAS_CHAR_W-1:0] receive_buffer_reg_r;
	logic [UFTAS_CHAR_W-1:0] transmit_holding_reg_r;
	logic                    hold_valid_r;
	logic [UFTAS_INT_W-1:0]  istat_r;
	logic [UFTAS_INT_W-1:0]  imask_r;
	logic [UFTAS_REG_W-1:0]  rdata_r;
	logic [UFTAS_REG_W-1:0]  rdata_nxt;
	logic                    irq_r;
	logic                    txv_r;
	logic [UFTAS_CHAR_W-1:0] txd_r;
	logic                    rx_full_d_r;
	logic [UFTAS_INT_W-1:0]  ev_set;
	logic                    fifos_on;
	logic                    wr_data;
	logic                    rd_data;
	logic                    wr_far;
	logic                    toggle;
	logic                    rx_full_flag;

	uftas_fifo_if #(.W(UFTAS_CHAR_W), .D(DEPTH)) rxf ();
	uftas_fifo_if #(.W(UFTAS_CHAR_W), .D(DEPTH)) txf ();

	// Address match used by every decoder
	function automatic logic hit(input logic [31:0] a, input logic [31:0] t);
		hit = (a == t);
	endfunction

	// Widen a character to register width
	function automatic logic [UFTAS_REG_W-1:0] widen(input logic [UFTAS_CHAR_W-1:0] c);
		widen = {{PADW{1'b0}}, c};
	endfunction

	// Access decode
	assign fifos_on = FIFO_PRESENT && fctl_en_r; // [RULE_08]
	assign wr_data  = reg_wr && hit(reg_addr, UFTAS_ADDR_DATA);
	assign rd_data  = reg_rd && hit(reg_addr, UFTAS_ADDR_DATA);
	assign wr_far   = reg_wr && hit(reg_addr, UFTAS_ADDR_FAR) && FIFO_ACCESS_PRESENT; // [RULE_01]
	assign toggle   = wr_far && (reg_wdata[UFTAS_FAR_BIT] != far_r);
	assign rx_full_flag = rxf.full; // [RULE_06] [RULE_07]

	// Test-access control bit
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			far_r <= UFTAS_FAR_RST;
		else if (wr_far)
			far_r <= reg_wdata[UFTAS_FAR_BIT]; // [RULE_01] [RULE_02]
	end

	// FIFO enable from the FIFO control register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			fctl_en_r <= UFTAS_FCTL_RST;
		else if (reg_wr && hit(reg_addr, UFTAS_ADDR_FCTL))
			fctl_en_r <= reg_wdata[UFTAS_FCTL_EN_BIT]; // [RULE_08]
	end

	// Receive FIFO: engine fills it normally, the master fills it in test access
	assign rxf.flush = toggle; // [RULE_05]
	assign rxf.push  = fifos_on && (far_r ? wr_data : rx_char_valid); // [RULE_03]
	assign rxf.wdata = far_r ? reg_wdata[UFTAS_CHAR_W-1:0] : rx_char_data;
	assign rxf.pop   = fifos_on && !far_r && rd_data;

	// Transmit FIFO: the master fills it in both modes, drains it in test access
	// Keeping the fill path in test access lets the master read back what it queued
	assign txf.flush = toggle; // [RULE_05]
	assign txf.push  = fifos_on && wr_data; // [RULE_03]
	assign txf.wdata = reg_wdata[UFTAS_CHAR_W-1:0];
	assign txf.pop   = fifos_on && (far_r ? rd_data : tx_char_req); // [RULE_03]

	uftas_fifo #(.W(UFTAS_CHAR_W), .D(DEPTH)) u_rx_fifo
	(
		.clock (clock),
		.rst_n (rst_n),
		.port  (rxf.fifo)
	);

	uftas_fifo #(.W(UFTAS_CHAR_W), .D(DEPTH)) u_tx_fifo
	(
		.clock (clock),
		.rst_n (rst_n),
		.port  (txf.fifo)
	);

	// Receive buffer used while FIFOs are off
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			receive_buffer_reg_r <= UFTAS_ZERO_CH;
		else if (!fifos_on && far_r && wr_data)
			receive_buffer_reg_r <= reg_wdata[UFTAS_CHAR_W-1:0]; // [RULE_04]
		else if (!fifos_on && !far_r && rx_char_valid)
			receive_buffer_reg_r <= rx_char_data;
	end

	// Transmit holding register used while FIFOs are off
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			transmit_holding_reg_r <= UFTAS_ZERO_CH;
			hold_valid_r           <= 1'b0;
		end
		else if (!fifos_on && !far_r && wr_data)
		begin
			transmit_holding_reg_r <= reg_wdata[UFTAS_CHAR_W-1:0];
			hold_valid_r           <= 1'b1;
		end
		else if (!fifos_on && !far_r && tx_char_req)
			hold_valid_r <= 1'b0;
	end

	// Character handed to the transmit engine, held back in test access
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			txv_r <= 1'b0;
			txd_r <= UFTAS_ZERO_CH;
		end
		else if (tx_char_req && !far_r && fifos_on && !txf.empty)
		begin
			txv_r <= 1'b1;
			txd_r <= txf.rdata;
		end
		else if (tx_char_req && !far_r && !fifos_on && hold_valid_r)
		begin
			txv_r <= 1'b1;
			txd_r <= transmit_holding_reg_r;
		end
		else
			txv_r <= 1'b0;
	end

	// Read data mux, zero for unmapped addresses
	always_comb
	begin
		rdata_nxt = UFTAS_ZERO_REG;
		if (!reg_rd)
			rdata_nxt = UFTAS_ZERO_REG;
		else if (hit(reg_addr, UFTAS_ADDR_DATA))
		begin
			if (far_r)
				rdata_nxt = fifos_on ? widen(txf.rdata) : widen(transmit_holding_reg_r); // [RULE_03] [RULE_04]
			else
				rdata_nxt = fifos_on ? widen(rxf.rdata) : widen(receive_buffer_reg_r);
		end
		else if (hit(reg_addr, UFTAS_ADDR_FCTL))
			rdata_nxt[UFTAS_FCTL_EN_BIT] = fctl_en_r;
		else if (hit(reg_addr, UFTAS_ADDR_FAR))
			rdata_nxt[UFTAS_FAR_BIT] = far_r; // [RULE_01]
		else if (hit(reg_addr, UFTAS_ADDR_USR))
			rdata_nxt[UFTAS_USR_RFF] = rx_full_flag; // [RULE_06]
		else if (hit(reg_addr, UFTAS_ADDR_ISTAT))
			rdata_nxt[UFTAS_INT_W-1:0] = istat_r;
		else if (hit(reg_addr, UFTAS_ADDR_IMASK))
			rdata_nxt[UFTAS_INT_W-1:0] = imask_r;
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rdata_r <= UFTAS_ZERO_REG;
		else
			rdata_r <= rdata_nxt;
	end

	// Interrupt events: full rising, mode toggle, push into full receive FIFO
	always_comb
	begin
		ev_set = UFTAS_INT_RST;
		ev_set[UFTAS_INT_RFF]    = rx_full_flag && !rx_full_d_r;
		ev_set[UFTAS_INT_TOGGLE] = toggle;
		ev_set[UFTAS_INT_OVR]    = rxf.push && rxf.full;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rx_full_d_r <= 1'b0;
		else
			rx_full_d_r <= rx_full_flag;
	end

	// Sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			istat_r <= UFTAS_INT_RST;
		else if (reg_wr && hit(reg_addr, UFTAS_ADDR_ISTAT))
			istat_r <= (istat_r & ~reg_wdata[UFTAS_INT_W-1:0]) | ev_set;
		else
			istat_r <= istat_r | ev_set;
	end

	// Interrupt mask
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			imask_r <= UFTAS_INT_RST;
		else if (reg_wr && hit(reg_addr, UFTAS_ADDR_IMASK))
			imask_r <= reg_wdata[UFTAS_INT_W-1:0];
	end

	// Level interrupt registered from the status and mask values, one cycle behind them
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			irq_r <= 1'b0;
		else
			irq_r <= |(istat_r & imask_r);
	end

	// Outputs straight from flip-flops
	assign reg_rdata               = rdata_r;
	assign tx_char_valid           = txv_r;
	assign tx_char_data            = txd_r;
	assign fifo_en                 = fctl_en_r;
	assign fifo_test_access_enable = far_r;
	assign irq                     = irq_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Named steps for the checks
	sequence s_far_write;
		reg_wr && hit(reg_addr, UFTAS_ADDR_FAR);
	endsequence

	sequence s_test_fifo_wr;
		far_r && fifos_on && wr_data && !rxf.full;
	endsequence

	sequence s_test_fifo_rd;
		far_r && fifos_on && rd_data && !txf.empty;
	endsequence

	sequence s_mode_flip;
		s_far_write ##0 (reg_wdata[UFTAS_FAR_BIT] != far_r) ##0 FIFO_ACCESS_PRESENT;
	endsequence

	a_far_locked: assert property (s_far_write ##0 !FIFO_ACCESS_PRESENT |=> $stable(far_r)) // [RULE_01]
		else $error("test access bit changed without build option");

	a_far_write_value: assert property ( // [RULE_02]
		s_far_write ##0 FIFO_ACCESS_PRESENT |=> far_r == $past(reg_wdata[UFTAS_FAR_BIT]))
		else $error("test access bit did not take written value");

	a_rx_fill_test: assert property ( // [RULE_03]
		s_test_fifo_wr |=> rxf.count == $past(rxf.count) + 1'b1)
		else $error("master write did not fill receive FIFO");

	a_tx_drain_test: assert property ( // [RULE_03]
		s_test_fifo_rd |=> reg_rdata == widen($past(txf.rdata)) ##0 txf.count == $past(txf.count) - 1'b1)
		else $error("master read did not drain transmit FIFO");

	a_rxbuf_test_write: assert property ( // [RULE_04]
		far_r && !fifos_on && wr_data |=> receive_buffer_reg_r == $past(reg_wdata[UFTAS_CHAR_W-1:0]))
		else $error("receive buffer not written in test access");

	a_hold_test_read: assert property ( // [RULE_04]
		far_r && !fifos_on && rd_data |=> reg_rdata == widen($past(transmit_holding_reg_r)))
		else $error("holding register not returned in test access");

	a_toggle_flush: assert property ( // [RULE_05]
		s_mode_flip |=> rxf.empty && txf.empty && far_r != $past(far_r))
		else $error("FIFOs not emptied on test access change");

	a_rff_report: assert property ( // [RULE_06]
		reg_rd && hit(reg_addr, UFTAS_ADDR_USR) |=> reg_rdata[UFTAS_USR_RFF] == $past(rxf.full)
			&& reg_rdata[UFTAS_REG_W-1:UFTAS_USR_RFF+1] == '0)
		else $error("receive FIFO full status wrong");

	a_rff_clear: assert property (rxf.full && rxf.pop |=> !rx_full_flag) // [RULE_07]
		else $error("full flag stuck after a slot freed");

	a_fctl_enable: assert property ( // [RULE_08]
		reg_wr && hit(reg_addr, UFTAS_ADDR_FCTL) |=> fifo_en == $past(reg_wdata[UFTAS_FCTL_EN_BIT]))
		else $error("FIFO enable did not follow control bit 0");

	// Interrupt, read port, engine and receive FIFO checks
	a_irq_follow: assert property (irq == $past(|(istat_r & imask_r)))
		else $error("interrupt line does not follow status and mask");

	a_event_sticks: assert property (
		|ev_set |=> (istat_r & $past(ev_set)) == $past(ev_set))
		else $error("status event lost");

	a_engine_hold: assert property (far_r && tx_char_req |=> !tx_char_valid)
		else $error("transmit engine served during test access");

	a_toggle_status: assert property (s_mode_flip |=> istat_r[UFTAS_INT_TOGGLE])
		else $error("test access change not recorded in status");

	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == UFTAS_ZERO_REG)
		else $error("read data left standing without a read");

	a_rx_test_hold: assert property ( // [RULE_03]
		far_r && rd_data |=> rxf.count == $past(rxf.count))
		else $error("master read disturbed receive FIFO in test access");

	a_rff_live: assert property (rx_full_flag == (rxf.count == DEPTH)) // [RULE_06] [RULE_07]
		else $error("full flag does not match receive FIFO fill level");
endmodule
`default_nettype wire

/* test/test_uftas_top.sv */
`default_nettype none
module test_uftas_top
	import uftas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DEPTH = UFTAS_DEPTH;

	logic                    clock;
	logic                    rst_n;
	logic [31:0]             reg_addr;
	logic [UFTAS_REG_W-1:0]  reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [UFTAS_REG_W-1:0]  reg_rdata;
	logic                    rx_char_valid;
	logic [UFTAS_CHAR_W-1:0] rx_char_data;
	logic                    tx_char_req;
	logic                    tx_char_valid;
	logic [UFTAS_CHAR_W-1:0] tx_char_data;
	logic                    fifo_en;
	logic                    fifo_test_access_enable;
	logic                    irq;
	logic                    noacc_enable;
	int                      mismatches = 0;
	int                      cmp_count = 0;
	int                      cycles = 0;

	// Build with test access present
	uftas_top #(.FIFO_PRESENT(1'b1), .FIFO_ACCESS_PRESENT(1'b1), .DEPTH(DEPTH)) u_dut (
		.clock                   (clock),
		.rst_n                   (rst_n),
		.reg_addr                (reg_addr),
		.reg_wdata               (reg_wdata),
		.reg_wr                  (reg_wr),
		.reg_rd                  (reg_rd),
		.reg_rdata               (reg_rdata),
		.rx_char_valid           (rx_char_valid),
		.rx_char_data            (rx_char_data),
		.tx_char_req             (tx_char_req),
		.tx_char_valid           (tx_char_valid),
		.tx_char_data            (tx_char_data),
		.fifo_en                 (fifo_en),
		.fifo_test_access_enable (fifo_test_access_enable),
		.irq                     (irq)
	);

	// Build without test access, sharing the same bus
	uftas_top #(.FIFO_PRESENT(1'b1), .FIFO_ACCESS_PRESENT(1'b0), .DEPTH(DEPTH)) u_dut_noacc (
		.clock                   (clock),
		.rst_n                   (rst_n),
		.reg_addr                (reg_addr),
		.reg_wdata               (reg_wdata),
		.reg_wr                  (reg_wr),
		.reg_rd                  (reg_rd),
		.reg_rdata               (),
		.rx_char_valid           (rx_char_valid),
		.rx_char_data            (rx_char_data),
		.tx_char_req             (tx_char_req),
		.tx_char_valid           (),
		.tx_char_data            (),
		.fifo_en                 (),
		.fifo_test_access_enable (noacc_enable),
		.irq                     ()
	);

	// Clock generator
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Prints the counts and the verdict
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cuts a hang short
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			mismatches++;
			$display("[ERR] %0t cycle ceiling reached", $time);
			stop_test();
		end
	end

	// Compares one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read, data checked in the following cycle
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// Receive engine hands over one character
	task automatic rxc(input logic [7:0] d);
		@(posedge clock);
		rx_char_data <= d;
		rx_char_valid <= 1'b1;
		@(posedge clock);
		rx_char_valid <= 1'b0;
	endtask

	// Transmit engine asks for one character
	task automatic txr(input logic v, input logic [7:0] d);
		@(posedge clock);
		tx_char_req <= 1'b1;
		@(posedge clock);
		tx_char_req <= 1'b0;
		#1;
		chk({15'h0000, tx_char_valid}, {15'h0000, v});
		if (v)
			chk({8'h00, tx_char_data}, {8'h00, d});
	endtask

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		reg_addr = 32'h0000_0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rx_char_valid = 1'b0;
		rx_char_data = 8'h00;
		tx_char_req = 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(UFTAS_ADDR_FAR, 16'h0000);
		rd(UFTAS_ADDR_USR, 16'h0000);
		rd(32'h5000_1FF0, 16'h0000);
		$display("test reset done");

		// FIFOs off: master loads the receive buffer, reads the holding register
		wr(UFTAS_ADDR_DATA, 16'h00C3);
		wr(UFTAS_ADDR_IMASK, 16'h0002);
		wr(UFTAS_ADDR_FAR, 16'h0001);
		chk({15'h0000, fifo_test_access_enable}, 16'h0001);
		chk({15'h0000, noacc_enable}, 16'h0000);
		rd(UFTAS_ADDR_FAR, 16'h0001);
		chk({15'h0000, irq}, 16'h0001);
		rd(UFTAS_ADDR_DATA, 16'h00C3);
		wr(UFTAS_ADDR_DATA, 16'h005A);
		rd(UFTAS_ADDR_ISTAT, 16'h0002);
		wr(UFTAS_ADDR_ISTAT, 16'h0002);
		wr(UFTAS_ADDR_IMASK, 16'h0000);
		wr(UFTAS_ADDR_FAR, 16'h0000);
		rd(UFTAS_ADDR_DATA, 16'h005A);
		chk({15'h0000, irq}, 16'h0000);
		rd(UFTAS_ADDR_ISTAT, 16'h0002);
		wr(UFTAS_ADDR_ISTAT, 16'h0002);
		$display("test buffer access done");

		// FIFOs on: master fills the receive FIFO, toggling empties it
		wr(UFTAS_ADDR_FCTL, 16'h0001);
		chk({15'h0000, fifo_en}, 16'h0001);
		rd(UFTAS_ADDR_FCTL, 16'h0001);
		wr(UFTAS_ADDR_FAR, 16'h0001);
		for (int i = 0; i < DEPTH; i++)
		begin
			wr(UFTAS_ADDR_DATA, 16'(i));
			if (i == DEPTH - 2)
				rd(UFTAS_ADDR_USR, 16'h0000);
		end
		rd(UFTAS_ADDR_USR, 16'h0010);
		rd(UFTAS_ADDR_DATA, 16'h0000);
		rd(UFTAS_ADDR_DATA, 16'h0001);
		rd(UFTAS_ADDR_USR, 16'h0010);
		wr(UFTAS_ADDR_FAR, 16'h0000);
		rd(UFTAS_ADDR_USR, 16'h0000);
		wr(UFTAS_ADDR_ISTAT, 16'h0007);
		$display("test fifo access done");

		// Engine fills the receive FIFO, one pop clears the full flag
		for (int i = 0; i < DEPTH; i++)
			rxc(8'hA0 + 8'(i));
		rxc(8'hFF);
		rd(UFTAS_ADDR_USR, 16'h0010);
		rd(UFTAS_ADDR_DATA, 16'h00A0);
		rd(UFTAS_ADDR_USR, 16'h0000);
		rd(UFTAS_ADDR_ISTAT, 16'h0005);
		$display("test full flag done");

		// Toggling test access discards queued transmit data
		wr(UFTAS_ADDR_DATA, 16'h0011);
		txr(1'b1, 8'h11);
		wr(UFTAS_ADDR_DATA, 16'h0022);
		wr(UFTAS_ADDR_DATA, 16'h0033);
		wr(UFTAS_ADDR_FAR, 16'h0001);
		txr(1'b0, 8'h00);
		wr(UFTAS_ADDR_FAR, 16'h0000);
		txr(1'b0, 8'h00);
		$display("test transmit flush done");
		stop_test();
	end
endmodule
`default_nettype wire
